// file: bench/pps_pad_model.sv
// Pad model: outside source, pull-up and floating level seen by the port.
`timescale 1ns/100ps
module pps_pad_model #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe_n,
	input wire logic [W-1:0] pad_pullup,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_lvl,
	output logic [W-1:0] pad_in
);
	logic [W-1:0] flt = '0;
	// An undriven pin without pull-up wanders every cycle.
	always @(posedge pclk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!pad_oe_n[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_lvl[i];
			end else if (pad_pullup[i]) begin
				pad_in[i] = 1'b1;
			end else begin
				pad_in[i] = flt[i];
			end
		end
	end
endmodule : pps_pad_model

// file: bench/tb.sv
// Self-checking bench of the port pin block with a pad model.
`timescale 1ns/100ps
module tb;
	import pps_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup;
	logic [7:0] pad_analog_link, schmitt_output_tap;
	logic sleep_clamp = 1'b0;
	logic [7:0] ext_irq_enable = '0, ext_en = '0, ext_lvl = '0;
	logic [7:0] pullup_override_enable = '0, pullup_override_value = '0;
	logic [7:0] direction_override_enable = 8'hFF;
	logic [7:0] direction_override_value = 8'hFF;
	logic [7:0] level_override_enable = '0, level_override_value = '0;
	logic [7:0] toggle_override_enable = '0;
	logic [7:0] input_gate_override_enable = '0;
	logic [7:0] input_gate_override_value = '0;
	int miscompares = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic err;

	always #50 pclk = ~pclk;

	pps_port #(.PIN_COUNT(8)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in,
		.pad_out, .pad_oe_n, .pad_pullup, .pad_analog_link, .sleep_clamp,
		.ext_irq_enable, .pullup_override_enable, .pullup_override_value,
		.direction_override_enable, .direction_override_value,
		.level_override_enable, .level_override_value,
		.toggle_override_enable, .input_gate_override_enable,
		.input_gate_override_value, .schmitt_output_tap);
	pps_pad_model #(.W(8)) u_pad (.pclk, .pad_out, .pad_oe_n, .pad_pullup,
		.ext_en, .ext_lvl, .pad_in);

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : chk

	// The flip mask changes the pad at the enable edge of the transfer.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, input logic [7:0] flip);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		ext_lvl <= ext_lvl ^ flip;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 8'h00);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 8'h00);
		chk(rd, exp);
	endtask : rdc

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdc(OFS_DIRECTION, RST_DIRECTION);
		rdc(OFS_OUTPUT_VALUE, RST_OUTPUT_VALUE);
		apb(1'b0, 12'h010, 32'h0000_0000, 8'h00);
		chk(err, 1'b1);
		chk(rd, RDATA_ZERO);
		ext_en <= 8'hF0;
		ext_lvl <= 8'h30;
		wr(OFS_OUTPUT_VALUE, 32'h0000_00A5);
		wr(OFS_DIRECTION, 32'h0000_000F);
		@(negedge pclk);
		chk(pad_oe_n, 8'hF0);
		chk(pad_out & 8'h0F, 8'h05);
		chk(pad_pullup, 8'hA0);
		chk(pad_analog_link, pad_in);
		@(posedge pclk);
		rdc(OFS_PIN_INPUT, 32'h0000_0035);
		wr(OFS_CONTROL, 32'h0000_0001);
		@(negedge pclk);
		chk(pad_pullup, 8'h00);
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_PIN_INPUT, 32'h0000_000F);
		rdc(OFS_OUTPUT_VALUE, 32'h0000_00AA);
		$display("test regs done");
	endtask : t_regs

	task automatic t_sync;
		apb(1'b0, OFS_PIN_INPUT, 32'h0000_0000, 8'h40);
		chk(rd, 32'h0000_003A);
		chk(schmitt_output_tap & 8'hF0, 8'h70);
		rdc(OFS_PIN_INPUT, 32'h0000_007A);
		$display("test sync done");
	endtask : t_sync

	task automatic t_ovr;
		@(posedge pclk);
		pullup_override_enable <= 8'hFF;
		pullup_override_value <= 8'h3C;
		direction_override_enable <= 8'hFF;
		direction_override_value <= 8'hF0;
		level_override_enable <= 8'hFF;
		level_override_value <= 8'h96;
		@(negedge pclk);
		chk(pad_pullup, 8'h3C);
		chk(pad_oe_n, 8'h0F);
		chk(pad_out, 8'h96);
		@(posedge pclk);
		pullup_override_enable <= 8'h00;
		direction_override_enable <= 8'h00;
		level_override_enable <= 8'h00;
		toggle_override_enable <= 8'h01;
		@(posedge pclk);
		toggle_override_enable <= 8'h00;
		rdc(OFS_OUTPUT_VALUE, 32'h0000_00AB);
		$display("test override done");
	endtask : t_ovr

	// All pins drive, so the pin input reads back the written level.
	task automatic t_loop;
		wr(OFS_DIRECTION, 32'h0000_00FF);
		wr(OFS_OUTPUT_VALUE, 32'h0000_005A);
		rdc(OFS_PIN_INPUT, 32'h0000_005A);
		$display("test loopback done");
	endtask : t_loop

	task automatic t_sleep;
		wr(OFS_DIRECTION, 32'h0000_0000);
		ext_en <= 8'hFF;
		ext_lvl <= 8'hFF;
		ext_irq_enable <= 8'h01;
		sleep_clamp <= 1'b1;
		input_gate_override_enable <= 8'h06;
		input_gate_override_value <= 8'h02;
		@(negedge pclk);
		chk(schmitt_output_tap, 8'h03);
		@(posedge pclk);
		sleep_clamp <= 1'b0;
		@(negedge pclk);
		chk(schmitt_output_tap, 8'hFB);
		$display("test sleep done");
	endtask : t_sleep

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		chk(pad_oe_n, 8'hFF);
		direction_override_enable <= 8'h00;
		presetn <= 1'b1;
		t_regs();
		t_sync();
		t_ovr();
		t_loop();
		t_sleep();
		complete_run();
	end
endmodule : tb

// file: rtl/pps_override.sv
// Override network deciding pull-up, driver, level and input enable.
`timescale 1ns/100ps
module pps_override #(
	parameter int W = 8
) (
	pps_ovr_if.pin ovr,
	input wire logic presetn,
	input wire logic [W-1:0] direction_bit,
	input wire logic [W-1:0] output_value_bit,
	input wire logic global_pullup_disable,
	input wire logic sleep_clamp,
	input wire logic [W-1:0] ext_irq_enable,
	input wire logic [W-1:0] pad_in,
	output logic [W-1:0] drive_en,
	output logic [W-1:0] drive_level,
	output logic [W-1:0] pullup_en,
	output logic [W-1:0] digital_in
);
	logic [W-1:0] normal_pullup;
	logic [W-1:0] input_enable;

	always_comb begin
		normal_pullup = ~direction_bit & output_value_bit &
			{W{~global_pullup_disable}};
		pullup_en = (ovr.pu_oe & ovr.pu_ov) | (~ovr.pu_oe & normal_pullup);
		drive_en = ((ovr.dd_oe & ovr.dd_ov) | (~ovr.dd_oe & direction_bit)) &
			{W{presetn}};
		drive_level = (ovr.pv_oe & ovr.pv_ov) |
			(~ovr.pv_oe & output_value_bit);
		input_enable = ~({W{sleep_clamp}} & ~ext_irq_enable);
		input_enable = (ovr.die_oe & ovr.die_ov) |
			(~ovr.die_oe & input_enable);
		digital_in = pad_in & input_enable;
	end
endmodule : pps_override

// file: rtl/pps_ovr_if.sv
// Per-pin override signals handed from peripherals to the pin logic.
`timescale 1ns/100ps
interface pps_ovr_if #(
	parameter int W = 8
);
	logic [W-1:0] pu_oe;
	logic [W-1:0] pu_ov;
	logic [W-1:0] dd_oe;
	logic [W-1:0] dd_ov;
	logic [W-1:0] pv_oe;
	logic [W-1:0] pv_ov;
	logic [W-1:0] pt_oe;
	logic [W-1:0] die_oe;
	logic [W-1:0] die_ov;
	modport src (
		output pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, pt_oe, die_oe, die_ov
	);
	modport pin (
		input pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, pt_oe, die_oe, die_ov
	);
endinterface : pps_ovr_if

// file: rtl/pps_pkg.sv
// Register map, field positions and reset values of the port pin block.
package pps_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PIN_COUNT_DEF = 8;
	localparam logic [ADDR_W-1:0] OFS_PIN_INPUT = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_DIRECTION = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_VALUE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h00C;
	localparam int CTRL_PULLUP_DISABLE_POS = 0;
	localparam logic [DATA_W-1:0] RST_DIRECTION = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_OUTPUT_VALUE = 32'h0000_0000;
	localparam logic RST_PULLUP_DISABLE = 1'b0;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
	typedef enum logic [3:0] {
		PPS_SEL_PIN = 4'b0001,
		PPS_SEL_DIR = 4'b0010,
		PPS_SEL_OUT = 4'b0100,
		PPS_SEL_CTL = 4'b1000
	} pps_sel_e;
endpackage : pps_pkg

// file: rtl/pps_port.sv
// Top of one general-purpose I/O port: registers, pin control, APB slave.
//
// Function
// - Pin input bit reads synchronized level regardless of direction bit.
// - Input path: clock-high transparent latch, then rising-edge register.
// - Pin transition reaches pin input bit within half to one and half cycles.
// - Software-driven level reads back after one cycle; reader waits one slot.
// - Sleep clamp grounds digital input in deep sleep states.
// - Clamp skipped on pins whose external interrupt is enabled.
// - Wake with clamped pin high gives rising edge to interrupt edge detectors.
// - Pull-up follows override value if enabled, else dir/out/disable 0b010.
// - Driver follows direction override when enabled, else direction bit.
// - Driven level follows level override when enabled, else output bit.
// - Toggle override enable inverts the stored output value bit.
// - Input enable override decides input enable, ignoring sleep state.
// - Schmitt output tap to peripherals is taken before the synchronizer.
// - Analog link connects directly to the pad for peripherals.
// - Strobes shared per port; clock, clamp, pull-up disable shared by all.
// - Writing one to pin input bit inverts matching output value bit.
// - Direction one drives output; input with output one enables pull-up.
// - Pins are tri-stated whenever reset is active, without a clock.
// - Global pull-up disable switches off all non-overridden pull-ups.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module pps_port
	import pps_pkg::*;
#(
	parameter int PIN_COUNT = pps_pkg::PIN_COUNT_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pps_pkg::ADDR_W-1:0] paddr,
	input wire logic [pps_pkg::DATA_W-1:0] pwdata,
	output logic [pps_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PIN_COUNT-1:0] pad_in,
	output logic [PIN_COUNT-1:0] pad_out,
	output logic [PIN_COUNT-1:0] pad_oe_n,
	output logic [PIN_COUNT-1:0] pad_pullup,
	output logic [PIN_COUNT-1:0] pad_analog_link,
	input wire logic sleep_clamp,
	input wire logic [PIN_COUNT-1:0] ext_irq_enable,
	input wire logic [PIN_COUNT-1:0] pullup_override_enable,
	input wire logic [PIN_COUNT-1:0] pullup_override_value,
	input wire logic [PIN_COUNT-1:0] direction_override_enable,
	input wire logic [PIN_COUNT-1:0] direction_override_value,
	input wire logic [PIN_COUNT-1:0] level_override_enable,
	input wire logic [PIN_COUNT-1:0] level_override_value,
	input wire logic [PIN_COUNT-1:0] toggle_override_enable,
	input wire logic [PIN_COUNT-1:0] input_gate_override_enable,
	input wire logic [PIN_COUNT-1:0] input_gate_override_value,
	output logic [PIN_COUNT-1:0] schmitt_output_tap
);
	import pps_pkg::*;

	localparam int W = PIN_COUNT;

	if (PIN_COUNT < 1 || PIN_COUNT > DATA_W) begin : g_check
		$error("PIN_COUNT must lie between 1 and the data width.");
	end

	////////////////////////////////////////////////////////////////////////
	// Register decode.

	function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
		unique case (addr)
			OFS_PIN_INPUT: decode = PPS_SEL_PIN;
			OFS_DIRECTION: decode = PPS_SEL_DIR;
			OFS_OUTPUT_VALUE: decode = PPS_SEL_OUT;
			OFS_CONTROL: decode = PPS_SEL_CTL;
			default: decode = 4'h0;
		endcase
	endfunction : decode

	logic [W-1:0] direction_bit;
	logic [W-1:0] output_value_bit;
	logic global_pullup_disable;
	logic [W-1:0] pin_input_bit;
	logic [W-1:0] next_direction_bit;
	logic [W-1:0] next_output_value_bit;
	logic next_global_pullup_disable;
	logic [DATA_W-1:0] next_prdata;
	logic [3:0] sel;
	logic wr_strobe;
	logic rd_setup;
	logic [W-1:0] drive_en;
	logic [W-1:0] digital_in;

	// Strobes are common to every pin of the port.
	assign sel = decode(paddr);
	assign wr_strobe = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & (sel == 4'h0);

	////////////////////////////////////////////////////////////////////////
	// Register next state.

	always_comb begin
		next_direction_bit = direction_bit;
		next_output_value_bit = output_value_bit;
		next_global_pullup_disable = global_pullup_disable;
		next_prdata = prdata;
		if (wr_strobe && sel == PPS_SEL_DIR) begin
			next_direction_bit = pwdata[W-1:0];
		end
		if (wr_strobe && sel == PPS_SEL_OUT) begin
			next_output_value_bit = pwdata[W-1:0];
		end
		if (wr_strobe && sel == PPS_SEL_PIN) begin
			next_output_value_bit = output_value_bit ^ pwdata[W-1:0];
		end
		// A peripheral toggle lands on top of any software write.
		next_output_value_bit = next_output_value_bit ^
			ovr.pt_oe;
		if (wr_strobe && sel == PPS_SEL_CTL) begin
			next_global_pullup_disable = pwdata[CTRL_PULLUP_DISABLE_POS];
		end
		if (rd_setup) begin
			next_prdata = RDATA_ZERO;
			unique case (sel)
				PPS_SEL_PIN: next_prdata[W-1:0] = pin_input_bit;
				PPS_SEL_DIR: next_prdata[W-1:0] = direction_bit;
				PPS_SEL_OUT: next_prdata[W-1:0] = output_value_bit;
				PPS_SEL_CTL: next_prdata[CTRL_PULLUP_DISABLE_POS] =
					global_pullup_disable;
				default: next_prdata = RDATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_bit <= RST_DIRECTION[W-1:0];
			output_value_bit <= RST_OUTPUT_VALUE[W-1:0];
			global_pullup_disable <= RST_PULLUP_DISABLE;
			prdata <= RDATA_ZERO;
		end else begin
			direction_bit <= next_direction_bit;
			output_value_bit <= next_output_value_bit;
			global_pullup_disable <= next_global_pullup_disable;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin path.

	pps_ovr_if #(.W(W)) ovr ();

	// Pins without a peripheral owner receive zeros from the integrator.
	assign ovr.pu_oe = pullup_override_enable;
	assign ovr.pu_ov = pullup_override_value;
	assign ovr.dd_oe = direction_override_enable;
	assign ovr.dd_ov = direction_override_value;
	assign ovr.pv_oe = level_override_enable;
	assign ovr.pv_ov = level_override_value;
	assign ovr.pt_oe = toggle_override_enable;
	assign ovr.die_oe = input_gate_override_enable;
	assign ovr.die_ov = input_gate_override_value;

	pps_override #(.W(W)) u_override (
		.ovr(ovr),
		.presetn(presetn),
		.direction_bit(direction_bit),
		.output_value_bit(output_value_bit),
		.global_pullup_disable(global_pullup_disable),
		.sleep_clamp(sleep_clamp),
		.ext_irq_enable(ext_irq_enable),
		.pad_in(pad_in),
		.drive_en(drive_en),
		.drive_level(pad_out),
		.pullup_en(pad_pullup),
		.digital_in(digital_in)
	);

	assign pad_oe_n = ~drive_en;
	// On wake the clamp releases, so a high clamped pin shows a rising edge here.
	assign schmitt_output_tap = digital_in;
	// The analog path is the pad level itself, in either direction.
	assign pad_analog_link = pad_in;

	pps_sync #(.W(W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(digital_in),
		.dout(pin_input_bit)
	);

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// The first edge after reset still shows the cleared register.
	property p_sync_delay;
		$past(presetn) |-> pin_input_bit == $past(digital_in);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("Synchronizer delay is not one clock.");

	property p_readback;
		(wr_strobe && sel == PPS_SEL_OUT && direction_bit == '1 &&
			level_override_enable == '0 && direction_override_enable == '0 &&
			input_gate_override_enable == '0 && !sleep_clamp &&
			toggle_override_enable == '0)
			##1 (pad_in == pad_out) [*2]
			|-> pin_input_bit == $past(pwdata[W-1:0], 2);
	endproperty
	a_readback: assert property (p_readback)
		else $error("Looped-back output not readable after one idle cycle.");

	property p_pin_read;
		rd_setup && sel == PPS_SEL_PIN
			|=> prdata[W-1:0] == $past(pin_input_bit);
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("Pin input read does not show the synchronized level.");

	property p_clamp;
		sleep_clamp |-> (schmitt_output_tap &
			~ext_irq_enable & ~input_gate_override_enable) == '0;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("Sleep clamp did not ground the digital input.");

	property p_irq_pin;
		sleep_clamp |-> ((schmitt_output_tap ^ pad_in) &
			ext_irq_enable & ~input_gate_override_enable) == '0;
	endproperty
	a_irq_pin: assert property (p_irq_pin)
		else $error("Interrupt-enabled pin was clamped in sleep.");

	property p_input_override;
		(schmitt_output_tap & input_gate_override_enable) ==
			(pad_in & input_gate_override_enable &
			input_gate_override_value);
	endproperty
	a_input_override: assert property (p_input_override)
		else $error("Input gate override not honoured.");

	property p_pullup;
		pad_pullup == ((pullup_override_enable & pullup_override_value) |
			(~pullup_override_enable & ~direction_bit & output_value_bit &
			{W{~global_pullup_disable}}));
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("Pull-up enable does not match its controls.");

	property p_driver;
		pad_oe_n == ~((direction_override_enable & direction_override_value) |
			(~direction_override_enable & direction_bit));
	endproperty
	a_driver: assert property (p_driver)
		else $error("Output driver enable does not match its controls.");

	property p_level;
		pad_out == ((level_override_enable & level_override_value) |
			(~level_override_enable & output_value_bit));
	endproperty
	a_level: assert property (p_level)
		else $error("Driven level does not match its controls.");

	property p_toggle;
		!wr_strobe |=> output_value_bit ==
			$past(output_value_bit ^ toggle_override_enable);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("Toggle override did not invert the output value.");

	property p_pin_write;
		wr_strobe && sel == PPS_SEL_PIN |=> output_value_bit ==
			$past(output_value_bit ^ pwdata[W-1:0] ^ toggle_override_enable);
	endproperty
	a_pin_write: assert property (p_pin_write)
		else $error("Writing ones to pin input did not toggle output value.");

	property p_reset_tristate;
		$past(!presetn) |-> pad_oe_n == ~(direction_override_enable &
			direction_override_value);
	endproperty
	a_reset_tristate: assert property (p_reset_tristate)
		else $error("Pins not tri-stated out of reset.");

	property p_unmapped;
		psel && penable && sel == 4'h0 |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped access not answered with an error.");

	c_sleep_wake: cover property (sleep_clamp ##1 !sleep_clamp);
	c_toggle_write: cover property (wr_strobe && sel == PPS_SEL_PIN);
	c_pullup_on: cover property (pad_pullup != '0 && !global_pullup_disable);
	c_override_drive: cover property (direction_override_enable != '0);
endmodule : pps_port

// file: rtl/pps_sync.sv
// Input synchronizer: clock-high transparent latch followed by a register.
`timescale 1ns/100ps
module pps_sync #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] sync_latch;

	// The latch opens while the clock is high and closes on the fall.
	// Nonblocking updates keep the register on the held value at the rise.
	always_latch begin
		if (!presetn) begin
			sync_latch <= '0;
		end else if (pclk) begin
			sync_latch <= din;
		end
	end

	// Only the register reads the latch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= '0;
		end else begin
			dout <= sync_latch;
		end
	end
endmodule : pps_sync
